// ===== scp_pkg.sv
// shared constants and types for the serial configuration port
package scp_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int         ADDR_W         = 10;
	localparam logic [9:0] ADDR_LAST      = 10'h232;
	localparam logic [9:0] ADDR_ONE       = 10'h001;
	localparam logic [9:0] ADDR_ZERO      = 10'h000;
	localparam logic [9:0] REG_CFG        = 10'h000;
	localparam logic [9:0] REG_RDSEL      = 10'h004;
	localparam logic [9:0] REG_UPDATE     = 10'h232;
	localparam logic [7:0] CFG_RESET      = 8'h18;
	localparam logic [7:0] LONG_MODE_MASK = 8'h18;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;
	localparam int         CFG_DIR_BIT    = 0;
	localparam int         CFG_LSB_BIT    = 1;
	localparam int         RDSEL_BIT      = 0;
	localparam int         UPD_BIT        = 0;

	// ----------------------------------------
	// instruction word
	// ----------------------------------------
	localparam int         RW_BIT         = 15;
	localparam int         LEN_HI_BIT     = 14;
	localparam int         LEN_LO_BIT     = 13;
	localparam logic [1:0] LEN_STREAM     = 2'h3;
	localparam logic [1:0] LEFT_NONE      = 2'h0;
	localparam logic [1:0] LEFT_ONE       = 2'h1;
	localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
	localparam logic [3:0] BIT_ZERO       = 4'h0;
	localparam logic [3:0] BIT_ONE        = 4'h1;
	localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;
	localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;

	// ----------------------------------------
	// framing states, gray along the path
	// ----------------------------------------
	typedef enum logic [2:0] {
		SCP_IDLE  = 3'h0,
		SCP_INSTR = 3'h1,
		SCP_DATA  = 3'h3,
		SCP_STALL = 3'h2,
		SCP_DONE  = 3'h6
	} scp_state_t;

endpackage

// ===== scp_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module scp_sync #(
	parameter int W = 3
) (
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	input  wire logic         ce_in,
	input  wire logic [W-1:0] d_in,
	input  wire logic [W-1:0] init_in,
	output logic      [W-1:0] q_out
);

	if (W < 1) begin : g_bad_width
		$error("scp_sync width must be at least one");
	end

	// ----------------------------------------
	// per bit stages
	// ----------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_ff;
		logic s2_ff;
		logic s3_ff;
		logic q_ff;
		always_ff @(posedge clock_in) begin
			// stages start at the pin's idle level, so no false edge after reset
			if (rst_in) begin
				s1_ff <= init_in[i];
				s2_ff <= init_in[i];
				s3_ff <= init_in[i];
				q_ff  <= init_in[i];
			end else if (ce_in) begin
				s1_ff <= d_in[i];
				s2_ff <= s1_ff;
				s3_ff <= s2_ff;
				if (s2_ff == s3_ff) begin
					q_ff <= s3_ff;
				end
			end
		end
		assign q_out[i] = q_ff;
	end

endmodule
`default_nettype wire

// ===== scp_regs.sv
// shadow buffer and active register arrays
`timescale 1ns/1ps
`default_nettype none
module scp_regs
	import scp_pkg::*;
#(
	parameter int NREG = 563
) (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic              wr_en_in,
	input  wire logic [ADDR_W-1:0] wr_addr_in,
	input  wire logic [7:0]        wr_data_in,
	input  wire logic [ADDR_W-1:0] rd_addr_in,
	output logic      [7:0]        rd_data_out,
	input  wire logic [ADDR_W-1:0] usr_addr_in,
	output logic      [7:0]        usr_data_out,
	output logic      [7:0]        cfg_out
);

	if (NREG <= int'(REG_RDSEL) || NREG > (1 << ADDR_W)) begin : g_bad_nreg
		$error("scp_regs register count out of range");
	end

	logic [7:0] shd_mem [NREG];
	logic [7:0] act_mem [NREG];
	logic       in_range;
	logic       upd;
	logic [7:0] wr_val;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	always_comb begin
		in_range = int'(wr_addr_in) < NREG;
		upd      = wr_en_in && wr_addr_in == REG_UPDATE && wr_data_in[UPD_BIT];
		wr_val   = (wr_addr_in == REG_CFG) ? (wr_data_in | LONG_MODE_MASK) : wr_data_in;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < NREG; i++) begin
				shd_mem[i] <= (i == int'(REG_CFG)) ? CFG_RESET : BYTE_ZERO;
			end
		end else if (ce_in && wr_en_in && in_range && wr_addr_in != REG_UPDATE) begin
			shd_mem[wr_addr_in] <= wr_val;
		end
	end

	// update copies the whole buffer; the port config acts at once
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int i = 0; i < NREG; i++) begin
				act_mem[i] <= (i == int'(REG_CFG)) ? CFG_RESET : BYTE_ZERO;
			end
		end else if (ce_in) begin
			if (upd) begin
				for (int i = 0; i < NREG; i++) begin
					act_mem[i] <= shd_mem[i];
				end
			end
			if (wr_en_in && wr_addr_in == REG_CFG) begin
				act_mem[REG_CFG] <= wr_val;
			end
		end
	end

	// ----------------------------------------
	// read ports
	// ----------------------------------------
	always_comb begin
		if (int'(rd_addr_in) >= NREG) begin
			rd_data_out = BYTE_ZERO;
		end else if (act_mem[REG_RDSEL][RDSEL_BIT]) begin
			rd_data_out = act_mem[rd_addr_in];
		end else begin
			rd_data_out = shd_mem[rd_addr_in];
		end
		usr_data_out = (int'(usr_addr_in) < NREG) ? act_mem[usr_addr_in] : BYTE_ZERO;
		cfg_out      = act_mem[REG_CFG];
	end

	a_update_copy: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && upd && !(wr_en_in && wr_addr_in == REG_CFG)
		|=> act_mem[REG_RDSEL] == $past(shd_mem[REG_RDSEL]))
		else $error("update did not copy buffer");

	a_long_mode: assert property (@(posedge clock_in) disable iff (rst_in)
		1'b1 |-> (act_mem[REG_CFG] & LONG_MODE_MASK) == LONG_MODE_MASK)
		else $error("long instruction bits lost");

endmodule
`default_nettype wire

// ===== scp_port.sv
// serial configuration port: pin sampling, framing and readback
`timescale 1ns/1ps
`default_nettype none
// How it works
// - write bits sampled on rising serial clock, read bits launched on falling
// - after reset the port is three-wire, direction select reads zero
// - direction select set: data pin input only, readback on separate pin
// - both data outputs released while chip select is high
// - short transfers may stall at byte boundaries and resume on select low
// - select rising off a byte boundary drops the transfer and goes idle
// - streaming moves bytes until select rises or the last address has been handled
// - sixteen-bit instruction word comes first on sixteen rising edges
// - top bit is read, next two are length, last thirteen are address
// - length codes 0,1,2 give one to three bytes, 3 streams
// - msb-first transfers decrement the address after each byte
// - writes land in a buffer, update bit copies all and self-clears
// - streaming writes cross reserved addresses without skipping
// - reads shift out n bytes, or stream until select rises or the last address is read
// - readback select bit picks buffer or active registers
// - lsb-first transfers increment the address after each byte
// - streaming stops once the last address has been handled
module scp_port
	import scp_pkg::*;
#(
	parameter int NREG = 563
) (
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic              chip_sel_n_in,
	input  wire logic              sclk_in,
	input  wire logic              serial_data_io_in,
	output logic                   serial_data_io_out,
	output logic                   serial_data_io_oe_out,
	output logic                   serial_data_out_pin_out,
	output logic                   serial_data_out_pin_oe_out,
	output logic                   busy_out,
	output logic                   port_direction_select_out,
	output logic                   lsb_first_out,
	input  wire logic [ADDR_W-1:0] act_addr_in,
	output logic      [7:0]        act_data_out
);

	if (NREG != int'(ADDR_LAST) + 1) begin : g_bad_nreg
		$error("scp_port register count must match last address");
	end

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [2:0] pin_q;
	logic       sclk_f;
	logic       cs_n_f;
	logic       sdi_f;
	logic       sclk_d_ff;
	logic       cs_n_d_ff;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_rise;
	logic       cs_fall;

	// select idles high, so its filter starts from one
	scp_sync #(
		.W (3)
	) u_sync (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.d_in     ({chip_sel_n_in, sclk_in, serial_data_io_in}),
		.init_in  (3'h4),
		.q_out    (pin_q)
	);

	assign cs_n_f = pin_q[2];
	assign sclk_f = pin_q[1];
	assign sdi_f  = pin_q[0];

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sclk_d_ff <= 1'b0;
			cs_n_d_ff <= 1'b1;
		end else if (ce_in) begin
			sclk_d_ff <= sclk_f;
			cs_n_d_ff <= cs_n_f;
		end
	end

	assign sclk_rise = sclk_f && !sclk_d_ff && !cs_n_f;
	assign sclk_fall = !sclk_f && sclk_d_ff && !cs_n_f;
	assign cs_rise   = cs_n_f && !cs_n_d_ff;
	assign cs_fall   = !cs_n_f && cs_n_d_ff;

	// ----------------------------------------
	// framing state
	// ----------------------------------------
	scp_state_t        state_ff;
	logic              resume_data_ff;
	logic [3:0]        bcnt_ff;
	logic [15:0]       rx_ff;
	logic [15:0]       nxt_rx;
	logic [7:0]        rx_byte;
	logic              rw_ff;
	logic              stream_ff;
	logic [1:0]        left_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [ADDR_W-1:0] nxt_addr;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0]        rd_data;
	logic [7:0]        cfg;
	logic [7:0]        usr_data;
	logic              lsb;
	logic              dir;
	logic              instr_end;
	logic              byte_end;
	logic              last_byte;
	logic              on_boundary;

	// only the two low bits are read, the host keeps the byte mirrored
	assign lsb = cfg[CFG_LSB_BIT];
	assign dir = cfg[CFG_DIR_BIT];

	always_comb begin
		nxt_rx      = lsb ? {sdi_f, rx_ff[15:1]} : {rx_ff[14:0], sdi_f};
		rx_byte     = lsb ? nxt_rx[15:8] : nxt_rx[7:0];
		instr_end   = state_ff == SCP_INSTR && sclk_rise && bcnt_ff == INSTR_LAST_BIT;
		byte_end    = state_ff == SCP_DATA && sclk_rise && bcnt_ff[2:0] == BYTE_LAST_BIT;
		last_byte   = stream_ff ? (addr_ff == ADDR_LAST) : (left_ff == LEFT_NONE);
		on_boundary = bcnt_ff[2:0] == BYTE_FIRST_BIT;
		// no address is skipped while stepping
		if (lsb) begin
			nxt_addr = addr_ff + ADDR_ONE;
		end else if (addr_ff == ADDR_ZERO) begin
			nxt_addr = ADDR_LAST;
		end else begin
			nxt_addr = addr_ff - ADDR_ONE;
		end
		// upper three address bits are ignored
		rd_addr = (state_ff == SCP_INSTR) ? nxt_rx[ADDR_W-1:0] : nxt_addr;
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state_ff       <= SCP_IDLE;
			resume_data_ff <= 1'b0;
		end else if (ce_in) begin
			if (cs_rise) begin
				unique case (state_ff)
					SCP_INSTR: begin
						if (bcnt_ff != BIT_ZERO && on_boundary) begin
							state_ff       <= SCP_STALL;
							resume_data_ff <= 1'b0;
						end else begin
							state_ff <= SCP_IDLE;
						end
					end
					SCP_DATA: begin
						if (on_boundary && !stream_ff) begin
							state_ff       <= SCP_STALL;
							resume_data_ff <= 1'b1;
						end else begin
							state_ff <= SCP_IDLE;
						end
					end
					SCP_STALL: state_ff <= SCP_STALL;
					SCP_IDLE:  state_ff <= SCP_IDLE;
					SCP_DONE:  state_ff <= SCP_IDLE;
				endcase
			end else if (cs_fall) begin
				if (state_ff == SCP_IDLE) begin
					state_ff <= SCP_INSTR;
				end else if (state_ff == SCP_STALL) begin
					state_ff <= resume_data_ff ? SCP_DATA : SCP_INSTR;
				end
			end else if (instr_end) begin
				state_ff <= SCP_DATA;
			end else if (byte_end && last_byte) begin
				state_ff <= SCP_DONE;
			end
		end
	end

	// bit count and receive shifter
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			bcnt_ff <= BIT_ZERO;
			rx_ff   <= 16'h0000;
		end else if (ce_in) begin
			if (state_ff == SCP_IDLE) begin
				bcnt_ff <= BIT_ZERO;
				rx_ff   <= 16'h0000;
			end else if (instr_end) begin
				bcnt_ff <= BIT_ZERO;
				rx_ff   <= nxt_rx;
			end else if (sclk_rise && (state_ff == SCP_INSTR || state_ff == SCP_DATA)) begin
				bcnt_ff <= bcnt_ff + BIT_ONE;
				rx_ff   <= nxt_rx;
			end
		end
	end

	// decoded instruction and address generator
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rw_ff     <= 1'b0;
			stream_ff <= 1'b0;
			left_ff   <= LEFT_NONE;
			addr_ff   <= ADDR_ZERO;
		end else if (ce_in) begin
			if (instr_end) begin
				rw_ff     <= nxt_rx[RW_BIT];
				stream_ff <= nxt_rx[LEN_HI_BIT:LEN_LO_BIT] == LEN_STREAM;
				left_ff   <= nxt_rx[LEN_HI_BIT:LEN_LO_BIT];
				addr_ff   <= nxt_rx[ADDR_W-1:0];
			end else if (byte_end) begin
				left_ff <= left_ff - LEFT_ONE;
				addr_ff <= nxt_addr;
			end
		end
	end

	// ----------------------------------------
	// register arrays
	// ----------------------------------------
	scp_regs #(
		.NREG (NREG)
	) u_regs (
		.clock_in     (clock_in),
		.rst_in       (rst_in),
		.ce_in        (ce_in),
		.wr_en_in     (byte_end && !rw_ff),
		.wr_addr_in   (addr_ff),
		.wr_data_in   (rx_byte),
		.rd_addr_in   (rd_addr),
		.rd_data_out  (rd_data),
		.usr_addr_in  (act_addr_in),
		.usr_data_out (usr_data),
		.cfg_out      (cfg)
	);

	// ----------------------------------------
	// readback shifter and pin drivers
	// ----------------------------------------
	logic [7:0] tx_ff;
	logic       out_bit_ff;
	logic       sdio_oe_ff;
	logic       sdo_oe_ff;
	logic       busy_ff;
	logic       dir_ff;
	logic       lsb_ff;
	logic [7:0] act_data_ff;

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tx_ff      <= BYTE_ZERO;
			out_bit_ff <= 1'b0;
		end else if (ce_in) begin
			if ((instr_end && nxt_rx[RW_BIT]) || (byte_end && rw_ff)) begin
				tx_ff <= rd_data;
			end else if (sclk_fall && state_ff == SCP_DATA && rw_ff) begin
				out_bit_ff <= lsb ? tx_ff[0] : tx_ff[7];
				tx_ff      <= lsb ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
			end
		end
	end

	// shared pin driven only in the read data phase
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			sdio_oe_ff <= 1'b0;
			sdo_oe_ff  <= 1'b0;
		end else if (ce_in) begin
			// shared pin taken only from the first falling edge of the read phase
			sdio_oe_ff <= !cs_n_f && state_ff == SCP_DATA && rw_ff && !dir
				&& (sdio_oe_ff || sclk_fall);
			sdo_oe_ff  <= !cs_n_f && dir;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			busy_ff     <= 1'b0;
			dir_ff      <= 1'b0;
			lsb_ff      <= 1'b0;
			act_data_ff <= BYTE_ZERO;
		end else if (ce_in) begin
			busy_ff     <= state_ff != SCP_IDLE;
			dir_ff      <= dir;
			lsb_ff      <= lsb;
			act_data_ff <= usr_data;
		end
	end

	assign serial_data_io_out         = out_bit_ff;
	assign serial_data_io_oe_out      = sdio_oe_ff;
	assign serial_data_out_pin_out    = out_bit_ff;
	assign serial_data_out_pin_oe_out = sdo_oe_ff;
	assign busy_out                   = busy_ff;
	assign port_direction_select_out  = dir_ff;
	assign lsb_first_out              = lsb_ff;
	assign act_data_out               = act_data_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_cs_high_hiz: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && cs_n_f |=> !sdio_oe_ff && !sdo_oe_ff)
		else $error("data pin driven while deselected");

	a_three_wire: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && !dir |=> !sdo_oe_ff)
		else $error("separate pin driven in three-wire mode");

	a_four_wire: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && dir |=> !sdio_oe_ff)
		else $error("shared pin driven in four-wire mode");

	a_instr_to_data: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && instr_end |=> state_ff == SCP_DATA && bcnt_ff == BIT_ZERO)
		else $error("instruction did not end after sixteen bits");

	a_odd_flush: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && cs_rise && state_ff == SCP_DATA && !on_boundary |=> state_ff == SCP_IDLE)
		else $error("partial byte not flushed");

	a_stall_resume: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && state_ff == SCP_STALL && cs_fall
		|=> state_ff == ($past(resume_data_ff) ? SCP_DATA : SCP_INSTR))
		else $error("stalled transfer resumed wrongly");

	a_msb_step: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && byte_end && !lsb && addr_ff != ADDR_ZERO
		|=> addr_ff == $past(addr_ff) - ADDR_ONE)
		else $error("address did not decrement");

	a_lsb_step: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && byte_end && lsb |=> addr_ff == $past(addr_ff) + ADDR_ONE)
		else $error("address did not increment");

	a_stream_stop: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && byte_end && stream_ff && addr_ff == ADDR_LAST |=> state_ff == SCP_DONE)
		else $error("stream passed last address");

	a_count_done: assert property (@(posedge clock_in) disable iff (rst_in)
		ce_in && byte_end && !stream_ff && left_ff == LEFT_NONE |=> state_ff == SCP_DONE)
		else $error("byte count not honoured");

	a_read_launch: assert property (@(posedge clock_in) disable iff (rst_in)
		!(ce_in && sclk_fall) |=> $stable(out_bit_ff))
		else $error("read bit changed off a falling edge");

	a_start_on_cs: assert property (@(posedge clock_in) disable iff (rst_in)
		state_ff == SCP_IDLE && !cs_fall |=> state_ff == SCP_IDLE)
		else $error("transfer started without select");

endmodule
`default_nettype wire

// ===== scp_host.sv
// host model driving the serial configuration port pins
`timescale 1ns/1ps
`default_nettype none
module scp_host #(
	parameter int HALF = 12
) (
	input  wire logic clock_in,
	input  wire logic sdio_in,
	input  wire logic sdo_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      sdio_out,
	output logic      sdio_oe_out
);
	logic lsb;
	logic four;
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdio_out = 1'b0;
		sdio_oe_out = 1'b0;
		lsb = 1'b0;
		four = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#3;
	endtask
	// select low before any clock edge
	task automatic start();
		cs_n_out = 1'b0;
		tick(HALF);
	endtask
	// byte boundary stall, clock parked high
	task automatic stall();
		cs_n_out = 1'b1;
		tick(HALF);
		cs_n_out = 1'b0;
		tick(HALF);
	endtask
	// end of frame, clock stands low while deselected
	task automatic stop();
		cs_n_out = 1'b1;
		tick(HALF);
		sclk_out = 1'b0;
		sdio_oe_out = 1'b0;
		tick(HALF);
	endtask
	// data set while clock low, read bit taken at rising edge
	task automatic shift(input logic [7:0] v, input int n, input bit rd, output logic [7:0] got);
		int k;
		got = 8'h00;
		for (int i = 0; i < n; i++) begin
			k = lsb ? i : 7 - i;
			sclk_out = 1'b0;
			sdio_oe_out = !rd;
			sdio_out = v[k];
			tick(HALF);
			sclk_out = 1'b1;
			got[k] = four ? sdo_in : sdio_in;
			tick(HALF);
		end
	endtask
	// instruction word, upper address bits zero
	task automatic instr(input bit rd, input logic [1:0] code, input logic [9:0] a);
		logic [15:0] w;
		logic [7:0]  g;
		w = {rd, code, 3'b000, a};
		shift(lsb ? w[7:0] : w[15:8], 8, 1'b0, g);
		shift(lsb ? w[15:8] : w[7:0], 8, 1'b0, g);
	endtask
endmodule
`default_nettype wire

// ===== test_scp_port.sv
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_scp_port;
	import scp_pkg::*;
	logic              clock_in = 1'b0;
	logic              rst_in = 1'b1;
	logic [ADDR_W-1:0] act_addr = '0;
	logic              cs_n, sclk, h_val, h_oe, d_val, d_oe, s_val, s_oe, busy, dir, lsb;
	logic              flt = 1'b0;
	logic              dq = 1'b0;
	logic [7:0]        act_q;
	wire logic         sdio_lvl = h_oe ? h_val : (d_oe ? d_val : flt);
	wire logic         sdo_lvl = s_oe ? s_val : flt;
	int                num_errors = 0;
	int                n_checks = 0;
	int                seed = 32'hc57d;
	int                cyc = 0;
	int                hi = 0;
	int                lo = 0;
	logic [7:0]        shd [0:562];
	logic [7:0]        act [0:562];
	logic [7:0]        wq [$];

	scp_port i_dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1), .chip_sel_n_in(cs_n),
		.sclk_in(sclk), .serial_data_io_in(sdio_lvl), .serial_data_io_out(d_val),
		.serial_data_io_oe_out(d_oe), .serial_data_out_pin_out(s_val),
		.serial_data_out_pin_oe_out(s_oe), .busy_out(busy), .port_direction_select_out(dir),
		.lsb_first_out(lsb), .act_addr_in(act_addr), .act_data_out(act_q));
	scp_host hm (.clock_in(clock_in), .sdio_in(sdio_lvl), .sdo_in(sdo_lvl), .cs_n_out(cs_n),
		.sclk_out(sclk), .sdio_out(h_val), .sdio_oe_out(h_oe));

	always #25 clock_in = ~clock_in;

	// ----------------------------------------
	// pin monitor and timeout
	// ----------------------------------------
	always @(posedge clock_in) begin
		flt <= ~flt;
		cyc <= cyc + 1;
		dq <= dir;
		hi <= cs_n ? hi + 1 : 0;
		lo <= cs_n ? 0 : lo + 1;
		if (hi > 8) `CHK({d_oe, s_oe}, 2'b00)
		if (dir === 1'b1) `CHK(d_oe, 1'b0)
		if (dir === 1'b1 && dq === 1'b1 && lo > 8) `CHK(s_oe, 1'b1)
		if (h_oe === 1'b1) `CHK(d_oe, 1'b0)
		if (cyc == 40000) begin
			num_errors++;
			report_and_stop();
		end
	end

	function automatic logic [7:0] m_rd(input int a);
		if (a >= 'h232) return 8'h00;
		return act[4][0] ? act[a] : shd[a];
	endfunction
	task automatic m_wr(input int a, input logic [7:0] b);
		if (a == 0) begin
			shd[0] = b | 8'h18;
			act[0] = b | 8'h18;
		end else if (a == 'h232) begin
			if (b[0]) act = shd;
		end else if (a < 'h232) shd[a] = b;
	endtask
	task automatic xact(input bit rd, input logic [1:0] code, input int a, input int nb, input bit st);
		logic [7:0] v, g;
		bit         fin;
		fin = 1'b0;
		hm.start();
		hm.instr(rd, code, a[9:0]);
		for (int i = 0; i < nb; i++) begin
			if (st) hm.stall();
			v = (wq.size() > 0) ? wq.pop_front() : 8'($random(seed));
			hm.shift(v, 8, rd, g);
			if (!fin && rd) `CHK(g, m_rd(a))
			if (!fin && !rd) m_wr(a, v);
			fin = fin || a == 'h232 || (code != LEN_STREAM && i == code);
			a = hm.lsb ? a + 1 : (a == 0 ? 'h232 : a - 1);
		end
		hm.stop();
		hm.lsb = act[0][CFG_LSB_BIT];
		hm.four = act[0][CFG_DIR_BIT];
	endtask
	task automatic chk_act(input int a, input int n);
		for (int i = 0; i < n; i++) begin
			act_addr = 10'(a + i);
			hm.tick(3);
			`CHK(act_q, act[a + i])
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		logic [7:0] g;
		for (int i = 0; i < 563; i++) begin
			shd[i] = 8'h00;
			act[i] = 8'h00;
		end
		shd[0] = CFG_RESET;
		act[0] = CFG_RESET;
		repeat (12) @(posedge clock_in);
		#3 rst_in = 1'b0;
		hm.tick(6);
		`CHK({busy, dir, lsb, d_oe, s_oe}, 5'h00)
		chk_act(0, 5);
		for (int c = 0; c < 3; c++) begin
			xact(0, 2'(c), 'h040 + 16 * c, c + 1, c == 1);
			xact(1, 2'(c), 'h040 + 16 * c, c + 1, c == 2);
		end
		chk_act('h03e, 36);
		wq = {8'h01};
		xact(0, 2'h0, 'h232, 1, 0);
		chk_act('h03e, 36);
		hm.start();
		hm.instr(0, 2'h1, 'h050);
		hm.stall();
		hm.shift(8'h5a, 8, 0, g);
		m_wr('h050, 8'h5a);
		hm.stall();
		hm.shift(8'hff, 3, 0, g);
		hm.stop();
		hm.start();
		hm.shift(8'hc3, 5, 0, g);
		hm.stop();
		xact(1, 2'h1, 'h050, 2, 0);
		wq = {8'h3c, 8'h18, 8'h01, 8'hee, 8'hee};
		xact(0, LEN_STREAM, 'h001, 5, 0);
		chk_act(0, 3);
		xact(1, LEN_STREAM, 'h003, 6, 0);
		wq = {8'h01, 8'h01};
		xact(0, 2'h0, 'h004, 1, 0);
		xact(0, 2'h0, 'h232, 1, 0);
		xact(0, 2'h0, 'h040, 1, 0);
		xact(1, 2'h0, 'h040, 1, 0);
		wq = {8'h99};
		xact(0, 2'h0, 'h000, 1, 0);
		`CHK(dir, 1'b1)
		xact(1, 2'h2, 'h052, 3, 1);
		wq = {8'hdb};
		xact(0, 2'h0, 'h000, 1, 0);
		`CHK(lsb, 1'b1)
		wq = {8'h77, 8'h88, 8'h01, 8'h55};
		xact(0, LEN_STREAM, 'h230, 4, 0);
		chk_act('h230, 2);
		xact(1, 2'h1, 'h230, 2, 0);
		report_and_stop();
	end
endmodule
`default_nettype wire
